// [pmm_consts.svh]
`ifndef PMM_CONSTS_SVH
`define PMM_CONSTS_SVH

// System clock rate in MHz.
`define PMM_CLK_MHZ 64'h0000_00C8
// Longest allowed spin-up, reload or speed-up transition, in seconds.
`define PMM_TRANS_MAX_S 64'h0000_001E
`define PMM_TRANS_MAX_CYC \
  (33'(`PMM_TRANS_MAX_S * `PMM_CLK_MHZ * 64'h000F_4240))
// Servo active window in idle, in microseconds, and its period in revolutions.
`define PMM_SERVO_WAKE_US 64'h0000_0064
`define PMM_SERVO_WAKE_CYC (15'(`PMM_SERVO_WAKE_US * `PMM_CLK_MHZ))
`define PMM_SERVO_REVS 4'hA
// Drive word held in reset: spindle enabled for spin-up, heads parked, servo quiet.
`define PMM_DRIVE_RST 5'h12

`endif

// [pmm_drive_model.sv]
`timescale 1ns/1ps
// Stands in for the spindle motor, actuator and channel that answer the manager.
module pmm_drive_model
  import pmm_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire pmm_drive_t drive_in,
  input wire pmm_state_t mode_in,
  input wire logic slow_in,
  output logic at_speed_out,
  output logic load_done_out,
  output logic op_done_out,
  output logic rev_tick_out
);
  logic [9:0] spin_ff;
  logic [3:0] rev_ff;
  logic [2:0] step_ff;
  pmm_state_t mode_ff;
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      spin_ff <= '0;
      rev_ff <= '0;
      step_ff <= '0;
      mode_ff <= PMM_SPINUP;
    end else begin
      spin_ff <= (drive_in.spin_en && !drive_in.low_speed) ? spin_ff + {9'h000, ~&spin_ff} : '0;
      rev_ff <= drive_in.spin_en ? rev_ff + 4'h1 : 4'h0;
      step_ff <= (mode_in != mode_ff) ? 3'h0 : step_ff + 3'h1;
      mode_ff <= mode_in;
    end
  end
  // A slow spindle takes longer than the 200-cycle transition limit the testbench gives the manager.
  assign at_speed_out = spin_ff >= (slow_in ? 10'h12C : 10'h028);
  assign rev_tick_out = (rev_ff == 4'hF);
  assign load_done_out = (mode_in == PMM_RELOAD) && (step_ff == 3'h5);
  assign op_done_out = (mode_in inside {PMM_SEEK, PMM_READ, PMM_WRITE}) && (step_ff == 3'h3);
endmodule : pmm_drive_model

// [pmm_pkg.sv]
package pmm_pkg;

  typedef enum logic [3:0] {
    PMM_SPINUP, PMM_RELOAD, PMM_SPEEDUP, PMM_IDLE, PMM_SEEK, PMM_READ, PMM_WRITE,
    PMM_UNLOAD_IDLE, PMM_LOWRPM_IDLE, PMM_STANDBY, PMM_SLEEP
  } pmm_state_t;

  typedef enum logic [3:0] {
    PMM_CMD_GO_IDLE, PMM_CMD_GO_STANDBY, PMM_CMD_GO_SLEEP, PMM_CMD_GO_UNLOAD,
    PMM_CMD_GO_LOWRPM, PMM_CMD_SEEK, PMM_CMD_READ, PMM_CMD_WRITE
  } pmm_cmd_code_t;

  typedef struct packed {
    logic valid;
    pmm_cmd_code_t code;
  } pmm_cmd_t;

  typedef struct packed {
    logic spin_en;
    logic low_speed;
    logic heads_loaded;
    logic park_lock;
    logic servo_awake;
  } pmm_drive_t;

endpackage : pmm_pkg

// [pmm_power_mode_mgr.sv]
`timescale 1ns/1ps
`include "pmm_consts.svh"
// Behaviour
// RULE_01: Starting from power down or a stopped spindle the block passes through spin-up.
// RULE_02: Unloaded idle keeps the spindle at rated speed with the heads unloaded.
// RULE_03: Idle runs the spindle, wakes the servo briefly every ten turns, takes commands at once.
// RULE_04: Standby stops the spindle, unloads the actuator and still takes commands at once.
// RULE_05: Sleep is stopped and unloaded and is left only by soft or hard reset, to standby.
// RULE_06: Standby to idle spins the spindle up to rated speed within the longest allowed time.
// RULE_07: Idle to standby is taken at once and the spindle is left to coast down.
// RULE_08: Standby and sleep switch into each other at once with the spindle stopped.
// RULE_09: Unloaded idle to idle reloads the heads at rated speed within the longest time.
// RULE_10: Idle to unloaded idle takes effect at once with the speed unchanged.
// RULE_11: Low-speed idle to idle raises the speed to rated within the longest time.
// RULE_12: Whenever the spindle is stopped the heads are locked in the parking position.
// RULE_13: Heads load or unload only between idle and unloaded or low-speed idle; the code also unloads them idle to standby and reloads after spin-up.
// RULE_14: Ready shows once diagnostics are done and a media command can run at once.
// RULE_15: A media command outside idle first brings the drive to idle, then runs.
module pmm_power_mode_mgr
  import pmm_pkg::*;
#(
  parameter logic [32:0] TRANS_MAX_CYC = `PMM_TRANS_MAX_CYC,
  parameter logic [14:0] SERVO_WAKE_CYC = `PMM_SERVO_WAKE_CYC
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire pmm_cmd_t cmd_in,
  output logic cmd_ready_out,
  input wire logic soft_rst_in,
  input wire logic hard_rst_in,
  input wire logic diag_done_in,
  input wire logic at_speed_in,
  input wire logic load_done_in,
  input wire logic op_done_in,
  input wire logic rev_tick_in,
  output pmm_drive_t drive_out,
  output pmm_state_t mode_out,
  output logic ready_out,
  output logic timeout_err_out
);

  function automatic logic is_media(input pmm_cmd_code_t c);
    is_media = (c == PMM_CMD_SEEK) || (c == PMM_CMD_READ) || (c == PMM_CMD_WRITE);
  endfunction : is_media

  pmm_state_t state_ff, nxt_state;
  pmm_cmd_code_t op_ff, nxt_op;
  logic pend_ff, nxt_pend;
  logic diag_ff, nxt_diag;
  logic [32:0] tmo_cnt_ff, nxt_tmo_cnt;
  logic tmo_err_ff, nxt_tmo_err;
  logic [3:0] rev_cnt_ff, nxt_rev_cnt;
  logic [14:0] wake_cnt_ff, nxt_wake_cnt;
  pmm_drive_t drive_ff, nxt_drive;
  logic take;
  logic in_trans;

  // Commands are taken in the resting modes except sleep; a pending media command blocks new ones.
  always_comb begin
    cmd_ready_out = !pend_ff && (state_ff == PMM_IDLE || // see RULE_03
                    state_ff == PMM_STANDBY || // see RULE_04
                    state_ff == PMM_UNLOAD_IDLE || state_ff == PMM_LOWRPM_IDLE);
    take = cmd_in.valid && cmd_ready_out;
    in_trans = (state_ff == PMM_SPINUP) || (state_ff == PMM_RELOAD) ||
               (state_ff == PMM_SPEEDUP);
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_pend = pend_ff;
    nxt_diag = diag_ff || diag_done_in;
    if (take && is_media(cmd_in.code)) begin
      nxt_op = cmd_in.code;
      nxt_pend = 1'b1;
    end
    unique case (state_ff)
      PMM_SPINUP: begin
        if (at_speed_in && diag_ff) begin
          nxt_state = PMM_RELOAD; // see RULE_01 RULE_06
        end
      end
      PMM_RELOAD: begin
        if (load_done_in) begin
          nxt_state = PMM_IDLE; // see RULE_09
        end
      end
      PMM_SPEEDUP: begin
        if (at_speed_in) begin
          nxt_state = PMM_IDLE; // see RULE_11
        end
      end
      PMM_IDLE: begin
        if (pend_ff) begin
          nxt_state = PMM_SEEK; // see RULE_15
          nxt_pend = 1'b0;
        end else if (take) begin
          unique case (cmd_in.code)
            PMM_CMD_GO_STANDBY, PMM_CMD_GO_SLEEP: nxt_state = PMM_STANDBY; // see RULE_07
            PMM_CMD_GO_UNLOAD: nxt_state = PMM_UNLOAD_IDLE; // see RULE_10 RULE_13
            PMM_CMD_GO_LOWRPM: nxt_state = PMM_LOWRPM_IDLE; // see RULE_13
            PMM_CMD_SEEK, PMM_CMD_READ, PMM_CMD_WRITE: begin
              nxt_state = PMM_SEEK; // see RULE_03
              nxt_pend = 1'b0;
            end
            default: nxt_state = PMM_IDLE;
          endcase
        end
      end
      PMM_UNLOAD_IDLE, PMM_LOWRPM_IDLE: begin
        if (take) begin
          if (cmd_in.code == PMM_CMD_GO_IDLE || is_media(cmd_in.code)) begin
            nxt_state = (state_ff == PMM_UNLOAD_IDLE) ? PMM_RELOAD : PMM_SPEEDUP; // see RULE_15
          end else if (cmd_in.code == PMM_CMD_GO_STANDBY ||
                       cmd_in.code == PMM_CMD_GO_SLEEP) begin
            nxt_state = PMM_STANDBY;
          end
        end
      end
      PMM_STANDBY: begin
        if (take) begin
          if (cmd_in.code == PMM_CMD_GO_SLEEP) begin
            nxt_state = PMM_SLEEP; // see RULE_08
          end else if (cmd_in.code != PMM_CMD_GO_STANDBY) begin
            nxt_state = PMM_SPINUP; // see RULE_06 RULE_15
          end
        end
      end
      PMM_SLEEP: begin
        if (soft_rst_in || hard_rst_in) begin
          nxt_state = PMM_STANDBY; // see RULE_05 RULE_08
        end
      end
      PMM_SEEK: begin
        if (op_done_in) begin
          nxt_state = (op_ff == PMM_CMD_READ) ? PMM_READ :
                      (op_ff == PMM_CMD_WRITE) ? PMM_WRITE : PMM_IDLE;
        end
      end
      PMM_READ, PMM_WRITE: begin
        if (op_done_in) begin
          nxt_state = PMM_IDLE;
        end
      end
    endcase
  end

  // Transition watchdog; the error stays set until reset.
  always_comb begin
    nxt_tmo_cnt = (in_trans && nxt_state == state_ff) ? tmo_cnt_ff + 33'h0_0000_0001 :
                  33'h0_0000_0000;
    nxt_tmo_err = tmo_err_ff || // see RULE_06 RULE_09 RULE_11
                  (in_trans && tmo_cnt_ff >= TRANS_MAX_CYC - 33'h0_0000_0001);
  end

  // Idle servo wakes for a fixed window once per ten revolutions.
  always_comb begin
    nxt_rev_cnt = rev_cnt_ff;
    nxt_wake_cnt = (wake_cnt_ff != 15'h0000) ? wake_cnt_ff - 15'h0001 : 15'h0000;
    if (state_ff != PMM_IDLE) begin
      nxt_rev_cnt = 4'h0;
    end else if (rev_tick_in) begin
      if (rev_cnt_ff == `PMM_SERVO_REVS - 4'h1) begin
        nxt_rev_cnt = 4'h0;
        nxt_wake_cnt = SERVO_WAKE_CYC; // see RULE_03
      end else begin
        nxt_rev_cnt = rev_cnt_ff + 4'h1;
      end
    end
  end

  // Spindle and actuator drive follow the mode entered next.
  always_comb begin
    nxt_drive.spin_en = !(nxt_state == PMM_STANDBY || // see RULE_04
                          nxt_state == PMM_SLEEP); // see RULE_05
    // Speed-up drives the spindle at rated speed, so the low-speed request drops on entry.
    nxt_drive.low_speed = (nxt_state == PMM_LOWRPM_IDLE); // see RULE_11
    nxt_drive.heads_loaded = (nxt_state == PMM_IDLE) || (nxt_state == PMM_SEEK) || // see RULE_13
                             (nxt_state == PMM_READ) || (nxt_state == PMM_WRITE); // see RULE_02
    nxt_drive.park_lock = !nxt_drive.spin_en || (nxt_state == PMM_SPINUP); // see RULE_12
    nxt_drive.servo_awake = (nxt_state == PMM_IDLE) ? (nxt_wake_cnt != 15'h0000) :
                            (nxt_drive.spin_en && nxt_state != PMM_UNLOAD_IDLE &&
                             nxt_state != PMM_LOWRPM_IDLE);
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= PMM_SPINUP;
      op_ff <= PMM_CMD_SEEK;
      pend_ff <= 1'b0;
      diag_ff <= 1'b0;
      tmo_cnt_ff <= 33'h0_0000_0000;
      tmo_err_ff <= 1'b0;
      rev_cnt_ff <= 4'h0;
      wake_cnt_ff <= 15'h0000;
      drive_ff <= `PMM_DRIVE_RST;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      pend_ff <= nxt_pend;
      diag_ff <= nxt_diag;
      tmo_cnt_ff <= nxt_tmo_cnt;
      tmo_err_ff <= nxt_tmo_err;
      rev_cnt_ff <= nxt_rev_cnt;
      wake_cnt_ff <= nxt_wake_cnt;
      drive_ff <= nxt_drive;
    end
  end

  assign drive_out = drive_ff;
  assign mode_out = state_ff;
  assign ready_out = diag_ff && (state_ff == PMM_IDLE) && !pend_ff; // see RULE_14
  assign timeout_err_out = tmo_err_ff;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_in_sleep;
    state_ff == PMM_SLEEP;
  endsequence
  sequence s_wake_req;
    soft_rst_in || hard_rst_in;
  endsequence
  sequence s_standby_read;
    state_ff == PMM_STANDBY && cmd_in.valid && cmd_in.code == PMM_CMD_READ;
  endsequence
  sequence s_spin_first;
    state_ff == PMM_SPINUP ##1 state_ff != PMM_SEEK;
  endsequence

  a_sleep_exit_standby: assert property ( // see RULE_05
    s_in_sleep ##0 s_wake_req |=> state_ff == PMM_STANDBY)
    else $error("sleep did not leave to standby on reset");
  a_sleep_stays_put: assert property ( // see RULE_05
    s_in_sleep ##0 !(soft_rst_in || hard_rst_in) |=> s_in_sleep)
    else $error("sleep left without reset");
  a_stopped_heads_parked: assert property ( // see RULE_12
    !drive_out.spin_en |-> drive_out.park_lock && !drive_out.heads_loaded)
    else $error("heads not parked with spindle stopped");
  a_unload_idle_drive: assert property ( // see RULE_02
    state_ff == PMM_UNLOAD_IDLE |->
    drive_out.spin_en && !drive_out.low_speed && !drive_out.heads_loaded)
    else $error("unloaded idle drive wrong");
  a_head_load_source: assert property ( // see RULE_13
    $rose(drive_out.heads_loaded) |-> $past(state_ff) inside {PMM_RELOAD, PMM_SPEEDUP})
    else $error("heads loaded outside reload");
  a_idle_takes_cmd: assert property ( // see RULE_03
    state_ff == PMM_IDLE && !pend_ff |-> cmd_ready_out)
    else $error("idle refused a command");
  a_idle_media_now: assert property ( // see RULE_03
    state_ff == PMM_IDLE && !pend_ff && cmd_in.valid && is_media(cmd_in.code) |=>
    state_ff == PMM_SEEK)
    else $error("idle did not start a media command at once");
  a_standby_takes_cmd: assert property ( // see RULE_04
    state_ff == PMM_STANDBY |-> cmd_ready_out && !drive_out.spin_en)
    else $error("standby refused a command");
  a_standby_to_idle: assert property ( // see RULE_06
    s_standby_read |=> s_spin_first)
    else $error("standby did not spin up first");
  a_speedup_full_rate: assert property ( // see RULE_11
    state_ff == PMM_SPEEDUP |-> drive_out.spin_en && !drive_out.low_speed)
    else $error("speed-up not driven at rated speed");
  a_media_from_idle: assert property ( // see RULE_15
    $rose(state_ff == PMM_SEEK) |-> $past(state_ff) == PMM_IDLE)
    else $error("seek entered outside idle");
  a_idle_unload_now: assert property ( // see RULE_10
    state_ff == PMM_IDLE && !pend_ff && cmd_in.valid && cmd_in.code == PMM_CMD_GO_UNLOAD |=>
    state_ff == PMM_UNLOAD_IDLE && drive_out.spin_en)
    else $error("unload idle not entered at once");
  a_trans_timeout: assert property ( // see RULE_06
    in_trans && tmo_cnt_ff == TRANS_MAX_CYC - 33'h0_0000_0001 |=> timeout_err_out)
    else $error("transition timeout not flagged");
  a_ready_needs_diag: assert property ( // see RULE_14
    ready_out |-> diag_ff && state_ff == PMM_IDLE && drive_out.heads_loaded && drive_out.spin_en)
    else $error("ready without diagnostics");

endmodule : pmm_power_mode_mgr

// [tb_drive_power_mode_manager.sv]
`timescale 1ns/1ps
module tb_drive_power_mode_manager
  import pmm_pkg::*;
;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  pmm_cmd_t cmd_in = '0;
  logic soft_rst = 1'b0, hard_rst = 1'b0, diag_done = 1'b0, slow = 1'b0;
  logic at_speed, load_done, op_done, rev_tick, cmd_ready, ready, tout;
  pmm_drive_t drive;
  pmm_state_t mode;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  always #2.5 mclk_in = ~mclk_in;
  pmm_power_mode_mgr #(.TRANS_MAX_CYC(33'h0_0000_00C8), .SERVO_WAKE_CYC(15'h0014)) i_dut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready),
    .soft_rst_in(soft_rst), .hard_rst_in(hard_rst), .diag_done_in(diag_done),
    .at_speed_in(at_speed), .load_done_in(load_done), .op_done_in(op_done),
    .rev_tick_in(rev_tick), .drive_out(drive), .mode_out(mode), .ready_out(ready),
    .timeout_err_out(tout));
  pmm_drive_model i_model (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .drive_in(drive), .mode_in(mode), .slow_in(slow),
    .at_speed_out(at_speed), .load_done_out(load_done), .op_done_out(op_done),
    .rev_tick_out(rev_tick));
  task automatic tally_and_finish();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk_mode(input pmm_state_t exp);
    compares++;
    if (mode !== exp) begin
      fails++;
      $display("[FAIL] %0t mode %s expected %s", $time, mode.name(), exp.name());
    end
  endtask : chk_mode
  task automatic chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk_bit
  // Holds the request until it is taken, then drops valid at the next falling edge.
  task automatic send_cmd(input pmm_cmd_code_t c);
    int n;
    n = 0;
    @(negedge mclk_in);
    cmd_in = '{valid: 1'b1, code: c};
    #1;
    while (cmd_ready !== 1'b1 && n < 500) begin
      @(negedge mclk_in);
      #1;
      n++;
    end
    chk_bit(cmd_ready, 1'b1, "command not taken");
    @(negedge mclk_in);
    cmd_in.valid = 1'b0;
  endtask : send_cmd
  task automatic wait_mode(input pmm_state_t exp, input int max);
    int n;
    n = 0;
    while (mode !== exp && n < max) begin
      @(negedge mclk_in);
      n++;
    end
    chk_mode(exp);
  endtask : wait_mode
  task automatic t_power_on();
    repeat (20) @(negedge mclk_in);
    chk_mode(PMM_SPINUP);
    chk_bit(drive.park_lock, 1'b1, "heads not parked in reset");
    nrst_in = 1'b1;
    repeat (100) @(negedge mclk_in);
    chk_bit(ready, 1'b0, "ready before diagnostics");
    diag_done = 1'b1;
    wait_mode(PMM_IDLE, 300);
    @(negedge mclk_in);
    chk_bit(ready, 1'b1, "not ready in idle");
  endtask : t_power_on
  task automatic t_idle_media();
    pmm_cmd_code_t ops[3];
    int n;
    ops = '{PMM_CMD_SEEK, PMM_CMD_READ, PMM_CMD_WRITE};
    foreach (ops[i]) begin
      send_cmd(ops[i]);
      chk_mode(PMM_SEEK);
      wait_mode(PMM_IDLE, 40);
    end
    n = 0;
    repeat (320) begin
      @(negedge mclk_in);
      n += int'(drive.servo_awake === 1'b1);
    end
    chk_bit(n >= 20 && n <= 60, 1'b1, "servo window count");
  endtask : t_idle_media
  task automatic t_unload();
    send_cmd(PMM_CMD_GO_UNLOAD);
    chk_mode(PMM_UNLOAD_IDLE);
    chk_bit(drive.spin_en, 1'b1, "spindle stopped when unloaded");
    chk_bit(drive.heads_loaded, 1'b0, "heads loaded when unloaded");
    send_cmd(PMM_CMD_GO_IDLE);
    chk_mode(PMM_RELOAD);
    wait_mode(PMM_IDLE, 200);
    chk_bit(drive.heads_loaded, 1'b1, "heads not reloaded");
  endtask : t_unload
  task automatic t_lowrpm_read();
    send_cmd(PMM_CMD_GO_LOWRPM);
    chk_mode(PMM_LOWRPM_IDLE);
    chk_bit(drive.low_speed, 1'b1, "low speed not set");
    send_cmd(PMM_CMD_READ);
    chk_mode(PMM_SPEEDUP);
    chk_bit(drive.low_speed, 1'b0, "speed-up held at low speed");
    wait_mode(PMM_IDLE, 200);
    @(negedge mclk_in);
    chk_mode(PMM_SEEK);
    wait_mode(PMM_IDLE, 40);
  endtask : t_lowrpm_read
  task automatic t_standby_sleep();
    send_cmd(PMM_CMD_GO_STANDBY);
    chk_mode(PMM_STANDBY);
    chk_bit(drive.spin_en, 1'b0, "spindle runs in standby");
    chk_bit(drive.park_lock, 1'b1, "heads free while stopped");
    for (int i = 0; i < 2; i++) begin
      send_cmd(PMM_CMD_GO_SLEEP);
      chk_mode(PMM_SLEEP);
      @(negedge mclk_in);
      cmd_in = '{valid: 1'b1, code: PMM_CMD_GO_IDLE};
      #1;
      chk_bit(cmd_ready, 1'b0, "command taken in sleep");
      @(negedge mclk_in);
      cmd_in.valid = 1'b0;
      soft_rst = (i == 0);
      hard_rst = (i == 1);
      @(negedge mclk_in);
      soft_rst = 1'b0;
      hard_rst = 1'b0;
      chk_mode(PMM_STANDBY);
    end
  endtask : t_standby_sleep
  task automatic t_standby_read();
    send_cmd(PMM_CMD_READ);
    chk_mode(PMM_SPINUP);
    wait_mode(PMM_RELOAD, 200);
    wait_mode(PMM_IDLE, 50);
    @(negedge mclk_in);
    chk_mode(PMM_SEEK);
    wait_mode(PMM_IDLE, 40);
    chk_bit(tout, 1'b0, "timeout on a quick spin-up");
  endtask : t_standby_read
  task automatic t_slow_spinup();
    send_cmd(PMM_CMD_GO_STANDBY);
    slow = 1'b1;
    send_cmd(PMM_CMD_GO_IDLE);
    repeat (250) @(negedge mclk_in);
    chk_bit(tout, 1'b1, "slow spin-up not flagged");
    wait_mode(PMM_IDLE, 300);
  endtask : t_slow_spinup
  initial begin
    t_power_on();
    t_idle_media();
    t_unload();
    t_lowrpm_read();
    t_standby_sleep();
    t_standby_read();
    t_slow_spinup();
    tally_and_finish();
  end
endmodule : tb_drive_power_mode_manager
